// File: logic_cell.sv
// Top of the programmable logic cell: tables, chains, register
`timescale 1ns/100ps
`default_nettype none
module logic_cell (
	input  wire logic                                ref_clk,
	input  wire logic                                rst_n,
	input  wire cell_pkg::cell_cfg_s                 cfg,
	input  wire logic                                chipResetEn,
	input  wire logic                                cellInputA,
	input  wire logic                                cellInputB,
	input  wire logic                                cellInputC,
	input  wire logic                                cellInputD,
	input  wire logic                                carryIn,
	input  wire logic                                cascadeIn,
	input  wire logic                                groupCtrlFirst_n,
	input  wire logic                                groupCtrlSecond_n,
	input  wire logic [cell_pkg::BUS_WIDTH-1:0]      busEn,
	input  wire logic [cell_pkg::BUS_WIDTH-1:0]      busData,
	output logic                                     localOut,
	output logic                                     globalOut,
	output logic                                     carryOut,
	output logic                                     cascadeOut,
	output logic                                     busOut
);
	logic rstMeta;
	logic rstSync_n;
	logic regQ;
	logic next_regQ;
	logic lutOut;
	logic lutIn3;
	logic regD;
	logic counterNext;
	logic loadMux;
	logic storeInverted;
	logic asyncClr;
	logic asyncSet;
	logic asyncLoad;
	logic cellValue;

	// Reset release through two flops
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rstMeta   <= 1'b0;
			rstSync_n <= 1'b0;
		end else begin
			rstMeta   <= 1'b1;
			rstSync_n <= rstMeta;
		end
	end

	function automatic logic lut4(input logic [15:0] m, input logic [3:0] sel);
		lut4 = m[sel];
	endfunction

	function automatic logic lut3(input logic [7:0] m, input logic [2:0] sel);
		lut3 = m[sel];
	endfunction

	// Table paths for each operating mode
	always_comb begin
		lutIn3 = cfg.useCarryIn ? carryIn : cellInputC; // [R1]
		lutOut = 1'b0;
		carryOut = 1'b0;
		counterNext = 1'b0;
		loadMux = 1'b0;
		unique case (cfg.opMode)
			cell_pkg::MODE_NORMAL: begin
				lutOut = lut4(cfg.lutMask,
					{cellInputD, lutIn3, cellInputB, cellInputA}); // [R1]
			end
			cell_pkg::MODE_ARITH: begin
				lutOut = lut3(cfg.lutMask[cell_pkg::SUM_OFFSET +: cell_pkg::LUT3_WIDTH],
					{carryIn, cellInputB, cellInputA}); // [R6]
				carryOut = lut3(cfg.lutMask[cell_pkg::CARRY_OFFSET +: cell_pkg::LUT3_WIDTH],
					{carryIn, cellInputB, cellInputA}); // [R6]
			end
			cell_pkg::MODE_UPDOWN: begin
				// Direction on input b, counter enable on carry-in
				counterNext = lut3(cfg.lutMask[cell_pkg::SUM_OFFSET +: cell_pkg::LUT3_WIDTH],
					{carryIn, cellInputB, regQ}); // [R8]
				carryOut = lut3(cfg.lutMask[cell_pkg::CARRY_OFFSET +: cell_pkg::LUT3_WIDTH],
					{carryIn, cellInputB, regQ}); // [R8]
				loadMux = cellInputD ? cellInputC : counterNext; // [R8]
				lutOut = loadMux;
			end
			cell_pkg::MODE_CLRCNT: begin
				counterNext = lut3(cfg.lutMask[cell_pkg::SUM_OFFSET +: cell_pkg::LUT3_WIDTH],
					{carryIn, cellInputB, regQ});
				carryOut = lut3(cfg.lutMask[cell_pkg::CARRY_OFFSET +: cell_pkg::LUT3_WIDTH],
					{carryIn, cellInputB, regQ});
				loadMux = cellInputD ? cellInputC : counterNext;
				lutOut = loadMux & ~cascadeIn; // [R10]
			end
		endcase
	end

	// Cascade combine, usable in normal and arithmetic modes of unpacked cells
	assign cascadeOut = (cfg.useCascade && !cfg.packReg)
		? (lutOut & cascadeIn) : lutOut; // [R2] [R7]

	assign cellValue = cfg.useCascade ? cascadeOut : lutOut;

	// Clear/preset decode from group lines, all active low
	assign storeInverted = (cfg.clrPre == cell_pkg::CP_LOAD_PRESET); // [R19]
	always_comb begin
		asyncClr  = 1'b0;
		asyncSet  = 1'b0;
		asyncLoad = 1'b0;
		unique case (cfg.clrPre) // [R13]
			cell_pkg::CP_CLEAR: begin
				asyncClr = !groupCtrlFirst_n || !groupCtrlSecond_n; // [R15]
			end
			cell_pkg::CP_PRESET: begin
				asyncSet = !groupCtrlFirst_n; // [R16]
			end
			cell_pkg::CP_CLEAR_PRESET: begin
				asyncClr = !groupCtrlSecond_n; // [R17]
				asyncSet = !groupCtrlFirst_n && groupCtrlSecond_n; // [R17]
			end
			cell_pkg::CP_LOAD_CLEAR: begin
				asyncClr = !groupCtrlSecond_n; // [R18]
				asyncLoad = !groupCtrlFirst_n; // [R18] [R20]
			end
			cell_pkg::CP_LOAD_PRESET: begin
				asyncClr = !groupCtrlSecond_n; // [R19]
				asyncLoad = !groupCtrlFirst_n; // [R19] [R20]
			end
			cell_pkg::CP_LOAD_ONLY: begin
				asyncLoad = !groupCtrlFirst_n; // [R20] [R9]
			end
		endcase
	end

	// Register input: packed cells register input d directly
	always_comb begin
		regD = cfg.packReg ? cellInputD : cellValue; // [R3]
		next_regQ = regQ;
		if (cellInputA) begin
			next_regQ = storeInverted ? ~regD : regD; // [R21] [R4]
		end
	end

	// Asynchronous load emulated with a priority latch-free flop path
	logic loadVal;
	assign loadVal = storeInverted ? ~cellInputC : cellInputC; // [R19]
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			regQ <= cell_pkg::REG_RESET; // [R14]
		end else if (chipResetEn && !rstSync_n) begin
			regQ <= cell_pkg::REG_RESET; // [R14]
		end else if (asyncClr) begin
			regQ <= 1'b0; // [R12]
		end else if (asyncSet) begin
			regQ <= 1'b1; // [R16]
		end else if (asyncLoad) begin
			regQ <= loadVal; // [R20] [R9]
		end else begin
			regQ <= next_regQ;
		end
	end

	// Output routing; configuration is held static while clocked
	logic regView;
	assign regView = storeInverted ? ~regQ : regQ;
	always_comb begin
		localOut  = cfg.localFromReg ? regView : cellValue; // [R5] [R22]
		globalOut = cfg.globalFromReg ? regView : cellValue; // [R5]
	end

	tristate_emul busMux (
		.drvEn   (busEn),
		.drvData (busData),
		.busOut  (busOut)
	);
endmodule
`default_nettype wire

// File: cell_pkg.sv
// Package of constants and types for the programmable logic cell
// How it works
// R1: Normal mode LUT third input selectable
// R2: LUT ANDed with cascade-in gives cascade-out; here cascade-out is the plain LUT when packReg is set
// R3: Packing lets input d feed register
// R4: Packed register keeps enable, clear, preset
// R5: Local and global outputs independently selectable
// R6: Arithmetic mode: sum and carry tables
// R7: Cascade usable alongside carry in arithmetic
// R8: Up/down counter with enable, direction, load
// R9: Counter loads asynchronously via clear/preset
// R10: Clearable counter ANDs load with not-clear
// R11: Emulated bus: contention low, idle high
// R12: Clear and preset active low, unused high
// R13: Six clear/preset configurations supported
// R14: Chip-wide reset overrides all register controls
// R15: Clear-only: either group line clears
// R16: Preset-only via load of constant one
// R17: First line presets, second line clears
// R18: Load-with-clear: first loads, second clears
// R19: Load-with-preset stores register inverted
// R20: First line asynchronously loads input c
// R21: Input a acts as synchronous clock enable
// R22: Configuration is static during operation
package cell_pkg;
	typedef enum logic [1:0] {
		MODE_NORMAL,
		MODE_ARITH,
		MODE_UPDOWN,
		MODE_CLRCNT
	} op_mode_e;

	typedef enum logic [2:0] {
		CP_CLEAR,
		CP_PRESET,
		CP_CLEAR_PRESET,
		CP_LOAD_CLEAR,
		CP_LOAD_PRESET,
		CP_LOAD_ONLY
	} clrpre_mode_e;

	typedef struct packed {
		op_mode_e     opMode;
		clrpre_mode_e clrPre;
		logic [15:0]  lutMask;
		logic         useCarryIn;
		logic         useCascade;
		logic         packReg;
		logic         localFromReg;
		logic         globalFromReg;
	} cell_cfg_s;

	localparam int       BUS_WIDTH   = 4;
	localparam logic     REG_RESET   = 1'b0;
	localparam logic     CTRL_IDLE   = 1'b1;
	localparam int       MASK_WIDTH  = 16;
	localparam int       LUT3_WIDTH  = 8;
	localparam int       SUM_OFFSET  = 0;
	localparam int       CARRY_OFFSET = 8;
endpackage

// File: tristate_emul.sv
// Emulated internal tri-state bus built as a multiplexer
`timescale 1ns/100ps
`default_nettype none
module tristate_emul (
	input  wire logic [cell_pkg::BUS_WIDTH-1:0] drvEn,
	input  wire logic [cell_pkg::BUS_WIDTH-1:0] drvData,
	output logic                                busOut
);
	always_comb begin
		if (drvEn == '0) begin
			busOut = 1'b1; // [R11]
		end else if ((drvEn & (drvEn - 1'b1)) != '0) begin
			busOut = 1'b0; // [R11]
		end else begin
			busOut = |(drvEn & drvData);
		end
	end
endmodule
`default_nettype wire

// File: logic_cell_checker.sv
// Port checker of the logic cell
`timescale 1ns/100ps
`default_nettype none
module logic_cell_checker (
	input wire logic				ref_clk,
	input wire logic				rst_n,
	input wire cell_pkg::cell_cfg_s			cfg,
	input wire logic				cellInputA,
	input wire logic				cellInputB,
	input wire logic				cellInputC,
	input wire logic				cellInputD,
	input wire logic				carryIn,
	input wire logic				cascadeIn,
	input wire logic				groupCtrlFirst_n,
	input wire logic				groupCtrlSecond_n,
	input wire logic [cell_pkg::BUS_WIDTH-1:0]	busEn,
	input wire logic				localOut,
	input wire logic				globalOut,
	input wire logic				carryOut,
	input wire logic				cascadeOut,
	input wire logic				busOut
);
	logic	lut;
	logic	quiet;
	assign lut = cfg.lutMask[{cellInputD, cfg.useCarryIn ? carryIn : cellInputC, cellInputB,
		cellInputA}];
	assign quiet = groupCtrlFirst_n && groupCtrlSecond_n;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	bus_idle_a: assert property (busEn == '0 |-> busOut) else $error("bus idle");
	bus_clash_a: assert property (!$onehot0(busEn) |-> !busOut) else $error("bus clash");
	table_out_a: assert property (cfg.opMode == cell_pkg::MODE_NORMAL && !cfg.useCascade
		&& !cfg.packReg && !cfg.localFromReg |-> localOut == lut) else $error("table");
	cascade_out_a: assert property (cfg.opMode == cell_pkg::MODE_NORMAL && cfg.useCascade
		&& !cfg.packReg |-> cascadeOut == (lut & cascadeIn)) else $error("cascade");
	arith_carry_a: assert property (cfg.opMode == cell_pkg::MODE_ARITH
		|-> carryOut == cfg.lutMask[cell_pkg::CARRY_OFFSET + {carryIn, cellInputB, cellInputA}])
		else $error("carry");
	packed_load_a: assert property (cfg.packReg && cfg.globalFromReg && quiet && cellInputA
		&& cfg.opMode == cell_pkg::MODE_NORMAL && $past(rst_n, 1) && $past(rst_n, 2)
		&& $past(rst_n, 3)
		|=> globalOut == $past(cellInputD)) else $error("packed load");
	enable_hold_a: assert property (cfg.packReg && cfg.globalFromReg && quiet && !cellInputA
		|=> $changed(cfg) || $stable(globalOut)) else $error("hold");
	group_clear_a: assert property (cfg.clrPre == cell_pkg::CP_CLEAR && cfg.globalFromReg
		&& !quiet |=> !globalOut) else $error("clear");
	cover property (cfg.opMode == cell_pkg::MODE_ARITH && carryOut);
	cover property (cfg.opMode == cell_pkg::MODE_CLRCNT && cascadeIn);
	cover property (!groupCtrlFirst_n && cfg.clrPre == cell_pkg::CP_LOAD_ONLY);
endmodule
`default_nettype wire

// File: neighbour_cells.sv
// Neighbouring cells: chain inputs and emulated bus drivers
`timescale 1ns/100ps
`default_nettype none
module neighbour_cells (
	input wire logic				ref_clk,
	output logic					carryIn,
	output logic					cascadeIn,
	output logic [cell_pkg::BUS_WIDTH-1:0]		busEn,
	output logic [cell_pkg::BUS_WIDTH-1:0]		busData
);
	integer	seed = 4;
	initial forever begin
		{carryIn, cascadeIn, busEn, busData} = (2 + 2 * cell_pkg::BUS_WIDTH)'($random(seed));
		@(negedge ref_clk);
	end
endmodule
`default_nettype wire

// File: tb.sv
// Self-checking bench of the logic cell
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
	$display("mismatch %s exp %b got %b", n, e, g); end end
module tb;
	logic				ref_clk = 0;
	logic				rst_n = 0;
	logic				a = 0, b = 0, c = 0, d = 0, q;
	logic				firstN = 1, secondN = 1;
	logic				carryIn, cascadeIn, localOut, globalOut, carryOut, cascadeOut, busOut;
	logic [cell_pkg::BUS_WIDTH-1:0]	busEn, busData;
	cell_pkg::cell_cfg_s		cfg = '0;
	integer				seed = 4, num_errors = 0, n_compared = 0, i;
	logic_cell DUT (.ref_clk, .rst_n, .cfg, .chipResetEn(1'b1), .cellInputA(a), .cellInputB(b),
		.cellInputC(c), .cellInputD(d), .carryIn, .cascadeIn, .groupCtrlFirst_n(firstN),
		.groupCtrlSecond_n(secondN), .busEn, .busData, .localOut, .globalOut, .carryOut,
		.cascadeOut, .busOut);
	neighbour_cells nb (.ref_clk, .carryIn, .cascadeIn, .busEn, .busData);
	function automatic logic lutNow();
		return cfg.lutMask[{d, cfg.useCarryIn ? carryIn : c, b, a}];
	endfunction
	function automatic logic busExp(logic [cell_pkg::BUS_WIDTH-1:0] en, dt);
		return (en == '0) ? 1'b1 : ($onehot(en) ? |(en & dt) : 1'b0);
	endfunction
	task automatic tick();
		@(posedge ref_clk);
		#1;
	endtask
	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic ctl(cell_pkg::clrpre_mode_e m, logic fv, logic sv, logic cv, logic ex);
		cfg.clrPre = m;
		{a, d} = {1'b1, ~ex};
		tick();
		{a, c, firstN, secondN} = {1'b0, cv, fv, sv};
		tick();
		`CHK("control", ex, globalOut)
		{firstN, secondN} = 2'b11;
	endtask
	initial forever #2.5 ref_clk = ~ref_clk;
	initial begin
		#100000;
		num_errors++;
		print_verdict();
	end
	initial begin
		{cfg.packReg, cfg.globalFromReg} = 2'b11;
		repeat (3) @(posedge ref_clk);
		#1;
		rst_n = 1;
		repeat (3) tick();
		`CHK("reset", cell_pkg::REG_RESET, globalOut)
		cfg = '0;
		for (i = 0; i < 64; i++) begin
			{cfg.lutMask, cfg.useCarryIn, cfg.useCascade, a, b, c, d} = 22'($random(seed));
			#1;
			if (cfg.useCascade)
				`CHK("cascade", lutNow() & cascadeIn, cascadeOut)
			else
				`CHK("table", lutNow(), localOut)
			tick();
		end
		$display("normal done");
		{cfg.opMode, cfg.useCascade} = {cell_pkg::MODE_ARITH, 1'b0};
		for (i = 0; i < 32; i++) begin
			{cfg.lutMask, a, b} = 18'($random(seed));
			#1;
			`CHK("sum", cfg.lutMask[{carryIn, b, a}], localOut)
			`CHK("carry", cfg.lutMask[cell_pkg::CARRY_OFFSET + {carryIn, b, a}], carryOut)
			tick();
		end
		$display("arith done");
		cfg = {cell_pkg::MODE_NORMAL, cell_pkg::CP_CLEAR, 16'($random(seed)), 5'h05};
		for (i = 0; i < 32; i++) begin
			{a, b, c, d} = 4'($random(seed)) | {i == 0, 3'h0};
			q = a ? d : q;
			tick();
			`CHK("packed reg", q, globalOut)
			`CHK("packed table", lutNow(), localOut)
		end
		{cfg.opMode, cfg.packReg} = {cell_pkg::MODE_CLRCNT, 1'b0};
		for (i = 0; i < 16; i++) begin
			{a, d, c} = {2'b11, 1'($random(seed))};
			#2;
			q = c & ~cascadeIn;
			tick();
			`CHK("clear count", q, globalOut)
		end
		cfg.opMode = cell_pkg::MODE_UPDOWN;
		for (i = 0; i < 16; i++) begin
			{cfg.lutMask, b, c, d} = 19'($random(seed));
			a = 1'b1;
			#2;
			`CHK("count carry", cfg.lutMask[cell_pkg::CARRY_OFFSET + {carryIn, b, q}], carryOut)
			q = d ? c : cfg.lutMask[{carryIn, b, q}];
			tick();
			`CHK("up down", q, globalOut)
		end
		$display("register done");
		{cfg.opMode, cfg.packReg} = {cell_pkg::MODE_NORMAL, 1'b1};
		ctl(cell_pkg::CP_CLEAR, 0, 1, 0, 0);
		ctl(cell_pkg::CP_CLEAR, 1, 0, 0, 0);
		ctl(cell_pkg::CP_PRESET, 0, 1, 0, 1);
		ctl(cell_pkg::CP_CLEAR_PRESET, 0, 1, 0, 1);
		ctl(cell_pkg::CP_CLEAR_PRESET, 1, 0, 0, 0);
		ctl(cell_pkg::CP_LOAD_CLEAR, 1, 0, 1, 0);
		ctl(cell_pkg::CP_LOAD_PRESET, 1, 0, 0, 1);
		ctl(cell_pkg::CP_LOAD_PRESET, 0, 1, 0, 0);
		ctl(cell_pkg::CP_LOAD_ONLY, 0, 1, 1, 1);
		{a, d} = 2'b11;
		tick();
		rst_n = 0;
		#1;
		`CHK("chip reset", cell_pkg::REG_RESET, globalOut)
		tick();
		rst_n = 1;
		$display("control done");
		for (i = 0; i < 64; i++) begin
			tick();
			`CHK("bus", busExp(busEn, busData), busOut)
		end
		$display("bus done");
		print_verdict();
	end
endmodule
bind logic_cell logic_cell_checker chk (.ref_clk, .rst_n, .cfg, .cellInputA, .cellInputB,
	.cellInputC, .cellInputD, .carryIn, .cascadeIn, .groupCtrlFirst_n, .groupCtrlSecond_n,
	.busEn, .localOut, .globalOut, .carryOut, .cascadeOut, .busOut);
`default_nettype wire
